// File: sim/nand_dev_model.sv
/*
 behavioural large-page nand device, no clock of its own.
 assumes registered host strobes; counts host protocol faults in viol.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model #(
   parameter X16 = 0,
   parameter [7:0] MAKER_ID = 8'h5A,
   parameter [7:0] DEVICE_ID = 8'h3C,
   parameter [11:0] BAD_BLOCK = 12'h003,
   parameter [11:0] FAIL_BLOCK = 12'h005
) (
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic output_strobe_n,
   input wire logic [15:0] io_out,
   input wire logic slow,
   output logic [15:0] io_in,
   output logic rb
);
   localparam [7:0] FOURTH = X16 ? 8'h55 : 8'h15;
   localparam int PAGE_MAX = X16 ? 1056 : 2112;
   localparam int SPARE = X16 ? 1024 : 2048;
   logic [15:0] mem [int];
   int last_page [int];
   logic [7:0] abyte [0:4];
   logic [17:0] row;
   logic [15:0] last_out;
   logic fail;
   int acnt, col, nin, mode, idx, viol, b;
   function automatic int key(input logic [17:0] r, input int c);
      return int'(r) * 4096 + c;
   endfunction
   task automatic go_busy(input int ns);
      fork
         begin
            #50 rb = 1'b0;
            #(slow ? 2 * ns : ns) rb = 1'b1;
         end
      join_none
   endtask
   initial begin
      rb = 1'b1;
      io_in = 16'h0000;
      last_out = 16'h0000;
      {viol, fail, mode, acnt, col, nin, idx, row} = '0;
      // marker on second page only; block zero never marked
      mem[key({BAD_BLOCK, 6'h01}, SPARE)] = 16'h0000;
   end
   always @(posedge we_n) begin
      if (!ce_n) begin
         if (X16 && (cle || ale) && io_out[15:8] != 8'h00) viol++;
         if (!rb) viol++;
         if (cle) begin
            acnt = 0;
            case (io_out[7:0])
               8'h30: begin mode = 0; go_busy(600); end
               8'h70: mode = 1;
               8'h90: begin mode = 2; idx = 0; end
               8'h80: nin = 0;
               8'h10, 8'h15: begin
                  if (nin > PAGE_MAX) viol++;
                  b = int'(row[17:6]);
                  // a retired block is poisoned for good
                  if (last_page.exists(b) ? int'(row[5:0]) != last_page[b] + 1
                      : row[5:0] != 6'h00) viol++;
                  fail = (row[17:6] == FAIL_BLOCK);
                  last_page[b] = fail ? 99 : int'(row[5:0]);
                  go_busy(io_out[7:0] == 8'h15 ? 400 : 1000);
               end
               default: ;
            endcase
         end else if (ale) begin
            if (acnt < 5) abyte[acnt] = io_out[7:0];
            acnt++;
            if (acnt == 5) begin
               col = X16 ? {abyte[1][2:0], abyte[0]} : {abyte[1][3:0], abyte[0]};
               row = {abyte[4][1:0], abyte[3], abyte[2]};
            end
         end else begin // ce may rise between data cycles
            mem[key(row, col)] = X16 ? io_out : {8'h00, io_out[7:0]};
            col++;
            nin++;
         end
      end
   end
   always @(negedge output_strobe_n) begin
      if (!ce_n) begin
         if (cle || ale || !we_n) viol++;
         case (mode)
            0: begin
               io_in = mem.exists(key(row, col)) ? mem[key(row, col)]
                  : (X16 ? 16'hFFFF : 16'h00FF);
               col++;
            end
            1: io_in = {8'h00, 7'h70, fail};
            default: begin
               io_in = {8'h00, idx == 0 ? MAKER_ID : idx == 1 ? DEVICE_ID
                  : idx == 2 ? 8'hA5 : FOURTH};
               idx++;
            end
         endcase
         last_out = io_in;
      end
   end
   // released bus flips, so a late sample cannot pass by luck
   always @(posedge output_strobe_n or posedge ce_n) io_in <= #15 ~last_out;
endmodule // nand_dev_model
`default_nettype wire

// File: sim/nand_host_props.sv
/*
 pin-level assertions for the nand host controller.
 assumes it is bound into nand_host and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module nand_host_props #(
   parameter X16 = 0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic done,
   input wire logic err,
   input wire logic wr_take,
   input wire logic ce_n,
   input wire logic cle,
   input wire logic ale,
   input wire logic we_n,
   input wire logic output_strobe_n,
   input wire logic [15:0] io_out,
   input wire logic io_oe,
   input wire logic rb
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // rb needs sync stages, so four low samples mean truly busy
   sequence s_busy; !rb [*4]; endsequence
   sequence s_out_pulse; !output_strobe_n ##1 output_strobe_n; endsequence
   property p_out_quiet; !output_strobe_n |-> !cle && !ale && we_n && !io_oe;
   endproperty
   a_out_quiet: assert property (p_out_quiet)
      else $error("bad strobes");
   property p_out_pulse; $fell(output_strobe_n) |-> s_out_pulse; endproperty
   a_out_pulse: assert property (p_out_pulse)
      else $error("long strobe");
   property p_latch_excl; !we_n |-> !(cle && ale); endproperty
   a_latch_excl: assert property (p_latch_excl)
      else $error("cle and ale");
   property p_ce_held; (!we_n || !output_strobe_n) |-> !ce_n; endproperty
   a_ce_held: assert property (p_ce_held)
      else $error("strobe, no ce");
   property p_take; wr_take |-> !we_n && io_oe && !cle && !ale; endproperty
   a_take: assert property (p_take)
      else $error("data cycle wrong");
   // err is set one cycle ahead of the done pulse
   property p_err_done; $rose(err) |=> done; endproperty
   a_err_done: assert property (p_err_done)
      else $error("err without done");
   property p_upper_zero;
      io_oe && (cle || ale) |-> (X16 == 0) || (io_out[15:8] == 8'h00);
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper bus set");
   property p_busy_idle; s_busy |-> we_n && output_strobe_n; endproperty
   a_busy_idle: assert property (p_busy_idle)
      else $error("strobe when busy");
   property p_addr_gap; $fell(ale) && !cle |-> we_n [*2]; endproperty
   a_addr_gap: assert property (p_addr_gap)
      else $error("data too soon");
endmodule // nand_host_props
bind nand_host nand_host_props #(.X16(X16)) props (.clk(clk), .rstn(rstn),
   .done(done), .err(err), .wr_take(wr_take), .ce_n(ce_n), .cle(cle),
   .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
   .io_out(io_out), .io_oe(io_oe), .rb(rb));
`default_nettype wire

// File: sim/testbench.sv
/*
 self-checking bench for nand_host in x8 form with a device model.
 assumes design sources and the device model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam [7:0] MAKER_ID = 8'h5A; // arbitrary value
   localparam [7:0] DEVICE_ID = 8'h3C; // arbitrary value
   logic clk, rstn, cmd_valid, wr_valid, slow, wgap, e;
   logic cmd_ready, done, err, wr_take, rd_valid, ce_n, cle, ale, we_n;
   logic output_strobe_n, io_oe, rb;
   logic [2:0] cmd_op;
   logic [11:0] cmd_block, cmd_col, cmd_len;
   logic [5:0] cmd_page;
   logic [17:0] fail_row;
   logic [15:0] wr_data, rd_data, io_out, io_in;
   logic [15:0] wq [$];
   logic [15:0] rdq [$];
   int mismatches, checks_done, ce_drops, d, p;
   nand_host #(.X16(0), .BUSY_LIMIT(15'h0040)) dut (.clk(clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_block(cmd_block),
      .cmd_page(cmd_page), .cmd_col(cmd_col), .cmd_len(cmd_len),
      .cmd_ready(cmd_ready), .done(done), .err(err), .fail_row(fail_row),
      .wr_data(wr_data), .wr_valid(wr_valid), .wr_take(wr_take),
      .rd_data(rd_data), .rd_valid(rd_valid), .ce_n(ce_n), .cle(cle),
      .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
      .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .rb(rb));
   nand_dev_model #(.X16(0), .MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID))
      partner (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .output_strobe_n(output_strobe_n), .io_out(io_out), .slow(slow),
      .io_in(io_in), .rb(rb));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(negedge ce_n) ce_drops++;
   always @(posedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task feed;
      int i, n;
      for (i = 0; i < wq.size(); i++) begin
         wr_data = wq[i];
         wr_valid = 1'b1;
         n = 0;
         do begin
            @(posedge clk);
            #1 n++;
         end while (wr_take !== 1'b1 && n < 200);
         // valid drops after the last word, and between words only when wgap is set
         if (wgap || i == wq.size() - 1) wr_valid = 1'b0;
         if (wgap && i < wq.size() - 1) begin
            repeat (4) @(posedge clk);
            #1 chk("ce released", 1, ce_n);
         end
      end
   endtask
   task wait_done;
      int n;
      n = 0;
      do begin @(posedge clk); #1; n++; end while (done !== 1'b1 && n < 10000);
      if (n >= 10000) chk("done seen", 1, 0);
   endtask
   task run_op(input [2:0] op, input [11:0] blk, input [5:0] pg,
      input [11:0] col, input [11:0] len);
      int n;
      {cmd_op, cmd_block, cmd_page, cmd_col, cmd_len} = {op, blk, pg, col, len};
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50) begin @(posedge clk); #1; n++; end
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      rdq.delete();
      fork
         feed();
         wait_done();
      join
      e = err;
   endtask
   task t_scan;
      d = ce_drops;
      run_op(3'h4, 12'h000, 6'h00, 12'h000, 12'h000);
      chk("block zero quiet", d, ce_drops);
      run_op(3'h4, 12'h001, 0, 0, 0);
      run_op(3'h4, 12'h002, 0, 0, 0);
      run_op(3'h4, 12'h003, 0, 0, 0);
      run_op(3'h4, 12'h005, 0, 0, 0);
      run_op(3'h4, 12'hABC, 0, 0, 0);
      run_op(3'h0, 12'h003, 0, 0, 1);
      chk("bad block read refused", 1, e);
      run_op(3'h1, 12'h003, 0, 0, 1);
      chk("bad block program refused", 1, e);
   endtask
   task t_id;
      run_op(3'h3, 0, 0, 0, 0);
      chk("id count", 4, rdq.size());
      chk("maker", {8'h00, MAKER_ID}, rdq[0]);
      chk("device", {8'h00, DEVICE_ID}, rdq[1]);
      chk("fourth", 16'h0015, rdq[3]);
   endtask
   task t_prog_read;
      wq = '{16'h00A1, 16'h00B2, 16'h00C3};
      run_op(3'h1, 12'h001, 6'h00, 0, 3);
      chk("program ok", 0, e);
      wq = '{};
      run_op(3'h0, 12'h001, 6'h00, 0, 4);
      chk("word 0", 16'h00A1, rdq[0]);
      chk("word 2", 16'h00C3, rdq[2]);
      chk("erased word", 16'h00FF, rdq[3]);
      run_op(3'h1, 12'h001, 6'h02, 0, 1);
      chk("skip page refused", 1, e);
      slow = 1'b1;
      wgap = 1'b1;
      wq = '{16'h0022, 16'h0033};
      run_op(3'h1, 12'h001, 6'h01, 0, 2);
      chk("next page ok", 0, e);
      {slow, wgap} = 2'b00;
   endtask
   task t_fail;
      wq = '{16'h0044};
      run_op(3'h1, 12'h005, 6'h00, 0, 1);
      chk("status fail", 1, e);
      chk("fail row", {12'h005, 6'h00}, fail_row);
      wq = '{};
      run_op(3'h1, 12'h005, 6'h01, 0, 1);
      chk("retired refused", 1, e);
   endtask
   task t_cache;
      for (p = 0; p < 63; p++) begin
         wq = '{p[15:0]};
         run_op(3'h2, 12'h002, p[5:0], 0, 1);
         chk("cache pass", 0, e);
      end
      wq = '{};
      run_op(3'h2, 12'h002, 6'h3F, 0, 1);
      chk("pass 64 refused", 1, e);
   endtask
   task t_addr_len;
      run_op(3'h0, 12'hABC, 6'h2A, 12'h835, 2);
      chk("spare word", 16'h00FF, rdq[1]);
      chk("row bytes", {12'hABC, 6'h2A}, partner.row);
      chk("column bytes", 12'h837, partner.col);
      run_op(3'h0, 12'h001, 6'h00, 0, 12'hFFF);
      chk("read clipped", 2112, rdq.size());
   endtask
   initial begin
      {rstn, cmd_valid, wr_valid, slow, wgap, cmd_op} = '0;
      {cmd_block, cmd_page, cmd_col, cmd_len, wr_data} = '0;
      {mismatches, checks_done, ce_drops} = '0;
      repeat (5) @(posedge clk);
      #1 chk("idle strobe", 1, we_n);
      rstn = 1'b1;
      t_scan();
      t_id();
      t_prog_read();
      t_fail();
      t_cache();
      t_addr_len();
      chk("device faults", 0, partner.viol);
      stop_test();
   end
   // the run needs some 8500 cycles; seven times that is a hang
   initial begin
      #(40 * 60000);
      mismatches++;
      stop_test();
   end
endmodule // testbench
`default_nettype wire

// File: src/nand_bad_table.v
/*
 invalid-block table: one bit per block, set means retired.
 assumes the host fills every entry by a scan before use; the array
 itself has no reset, so unscanned entries are undefined.
*/
`timescale 1ns/1ps
`default_nettype none

module nand_bad_table #(
   parameter AW = 12
) (
   input wire clk,
   input wire rstn,
   input wire wen,
   input wire [AW-1:0] waddr,
   input wire wbad,
   input wire [AW-1:0] raddr,
   output reg bad_q
);
   reg mem [0:(1 << AW) - 1];

   always @(posedge clk) begin
      if (wen)
         mem[waddr] <= wbad;
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn)
         bad_q <= 1'b0;
      else
         bad_q <= mem[raddr];
   end
endmodule // nand_bad_table

`default_nettype wire

// File: src/nand_host.v
/*
 nand flash host controller: drives the strobes and the data bus of a
 large-page nand device for page read, page program, cache program,
 id read and factory marker scan, and keeps the invalid-block table.
 assumes one 25 MHz clock, a device on the pins with ready/busy, and a
 user that fills the table by scanning every block before other work.
*/
// Notes on behaviour
// - table is built from original markers; no erase is ever issued.
// - accesses to blocks marked invalid are refused.
// - failed program status retires the block in the table.
// - single-bit read errors go to ecc upstream, no retirement.
// - failing row reported for copy; retired block never programmed again.
// - pages are programmed strictly ascending from zero; order is kept for the last programmed block only.
// - chip enable released while data loading waits for the user.
// - x8 address bytes: A0-A7, A8-A11, A12-A19, A20-A27, A28-A29.
// - x16 address bytes: A0-A7, A8-A10, A11-A18, A19-A26, A27-A28.
// - x16 upper data lines are zero in command and address cycles.
// - data-in length is clipped to 2112 bytes or 1056 words.
// - serial output keeps command and address strobes low, write high.
// - at most 63 cache-program passes in one block, each with 15h.
// - address-to-data gap kept before the first data write.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_defines.vh"

module nand_host #(
   parameter X16 = 0,
   parameter [14:0] BUSY_LIMIT = `T_CBSY_CYC
) (
   input wire clk,
   input wire rstn,
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire [11:0] cmd_block,
   input wire [5:0] cmd_page,
   input wire [11:0] cmd_col,
   input wire [11:0] cmd_len,
   output reg cmd_ready,
   output reg done,
   output reg err,
   output reg [17:0] fail_row,
   input wire [15:0] wr_data,
   input wire wr_valid,
   output reg wr_take,
   output reg [15:0] rd_data,
   output reg rd_valid,
   output reg ce_n,
   output reg cle,
   output reg ale,
   output reg we_n,
   output reg output_strobe_n,
   output reg [15:0] io_out,
   output reg io_oe,
   input wire [15:0] io_in,
   input wire rb
);
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_CHECK = 4'h1;
   localparam [3:0] S_CMD = 4'h2;
   localparam [3:0] S_ADDR = 4'h3;
   localparam [3:0] S_GAP = 4'h4;
   localparam [3:0] S_WAIT = 4'h5;
   localparam [3:0] S_DIN = 4'h6;
   localparam [3:0] S_DOUT = 4'h7;
   localparam [3:0] S_DONE = 4'h8;
   // busy gaps also cover the synchroniser delay on ready/busy
   localparam integer ADL_CYC = `T_ADL_CYC;
   localparam integer WB_CYC = `T_WB_CYC + `SYNC_STAGES;
   localparam integer WHR_CYC = `T_WHR_CYC;
   localparam [3:0] GAP_ADL = ADL_CYC[3:0];
   localparam [3:0] GAP_WB = WB_CYC[3:0];
   localparam [3:0] GAP_WHR = WHR_CYC[3:0];

   reg [3:0] state;
   reg [3:0] gap_next;
   reg [3:0] gap_cnt;
   reg [2:0] op;
   reg [11:0] blk;
   reg [5:0] pg;
   reg [11:0] col;
   reg [11:0] len;
   reg [11:0] cnt;
   reg ph;
   reg [7:0] cmd_byte;
   reg [14:0] busy_cnt;
   reg prog_valid;
   reg [11:0] prog_blk;
   reg [6:0] prog_next;
   reg [5:0] cache_cnt;
   reg bbt_wen;
   reg bbt_wbad;
   reg [7:0] addr_byte;
   wire rb_s;
   wire bad_q;
   wire [17:0] row = {blk, pg};
   wire [11:0] page_max = X16 ? `PAGE_MAX_X16 : `PAGE_MAX_X8;
   wire [11:0] spare_col = X16 ? `SPARE_COL_X16 : `SPARE_COL_X8;
   wire [11:0] addr_last = (op == `OP_ID) ? 12'h000 : `ADDR_LAST;
   wire same_blk = prog_valid && (blk == prog_blk);
   wire order_ok = same_blk ? ({1'b0, pg} == prog_next) : (pg == 6'h00);
   wire marker_bad = X16 ? (rd_data != 16'hFFFF) :
                     (rd_data[7:0] != 8'hFF);

   nand_pin_sync #(.W(1), .INIT(1'b1)) u_rb_sync (
      .clk(clk),
      .rstn(rstn),
      .d(rb),
      .q(rb_s)
   );

   nand_bad_table #(.AW(12)) u_table (
      .clk(clk),
      .rstn(rstn),
      .wen(bbt_wen),
      .waddr(blk),
      .wbad(bbt_wbad),
      .raddr(cmd_block),
      .bad_q(bad_q)
   );

   always @* begin
      case (cnt[2:0])
      3'h0: addr_byte = (op == `OP_ID) ? 8'h00 : col[7:0];
      3'h1: addr_byte = X16 ? {5'h00, col[10:8]} :
                              {4'h0, col[11:8]};
      3'h2: addr_byte = row[7:0];
      3'h3: addr_byte = row[15:8];
      default: addr_byte = {6'h00, row[17:16]};
      endcase
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
         gap_next <= S_IDLE;
         gap_cnt <= 4'h0;
         op <= 3'h0;
         blk <= 12'h000;
         pg <= 6'h00;
         col <= 12'h000;
         len <= 12'h000;
         cnt <= 12'h000;
         ph <= 1'b0;
         cmd_byte <= 8'h00;
         busy_cnt <= 15'h0000;
         prog_valid <= 1'b0;
         prog_blk <= 12'h000;
         prog_next <= 7'h00;
         cache_cnt <= 6'h00;
         bbt_wen <= 1'b0;
         bbt_wbad <= 1'b0;
         cmd_ready <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         fail_row <= 18'h00000;
         wr_take <= 1'b0;
         rd_data <= 16'h0000;
         rd_valid <= 1'b0;
         ce_n <= 1'b1;
         cle <= 1'b0;
         ale <= 1'b0;
         we_n <= 1'b1;
         output_strobe_n <= 1'b1;
         io_out <= 16'h0000;
         io_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         wr_take <= 1'b0;
         rd_valid <= 1'b0;
         bbt_wen <= 1'b0;
         case (state)
         S_IDLE: begin
            cmd_ready <= 1'b1;
            if (cmd_valid && cmd_ready) begin
               cmd_ready <= 1'b0;
               err <= 1'b0;
               op <= cmd_op;
               blk <= cmd_block;
               pg <= cmd_page;
               col <= cmd_col;
               len <= (cmd_len > page_max) ? page_max : cmd_len;
               // block zero scan touches no pin at all
               ce_n <= (cmd_op == `OP_SCAN) && (cmd_block == 12'h000);
               state <= S_CHECK;
            end
         end
         S_CHECK: begin
            ph <= 1'b0;
            state <= S_CMD;
            case (op)
            `OP_SCAN: begin
               if (blk == 12'h000) begin
                  bbt_wen <= 1'b1;
                  bbt_wbad <= 1'b0;
                  state <= S_DONE;
               end else begin
                  col <= spare_col;
                  pg <= 6'h00;
                  len <= 12'h001;
                  cmd_byte <= `CMD_READ;
               end
            end
            `OP_READ: begin
               cmd_byte <= `CMD_READ;
               if (bad_q) begin
                  err <= 1'b1;
                  state <= S_DONE;
               end
            end
            `OP_PROG, `OP_CACHE: begin
               cmd_byte <= `CMD_DATA_IN;
               if (bad_q || !order_ok || (op == `OP_CACHE &&
                   same_blk && cache_cnt == `CACHE_MAX)) begin
                  err <= 1'b1;
                  state <= S_DONE;
               end
            end
            `OP_ID: begin
               cmd_byte <= `CMD_READ_ID;
               len <= `ID_BYTES;
            end
            default: begin
               // erase is deliberately not offered: markers stay intact
               err <= 1'b1;
               state <= S_DONE;
            end
            endcase
         end
         S_CMD: begin
            if (!ph) begin
               cle <= 1'b1;
               ale <= 1'b0;
               io_oe <= 1'b1;
               io_out <= {8'h00, cmd_byte};
               we_n <= 1'b0;
               ph <= 1'b1;
            end else begin
               we_n <= 1'b1;
               ph <= 1'b0;
               cnt <= 12'h000;
               busy_cnt <= 15'h0000;
               case (cmd_byte)
               `CMD_READ, `CMD_DATA_IN, `CMD_READ_ID: state <= S_ADDR;
               `CMD_READ_GO, `CMD_PROG_GO, `CMD_CACHE_GO: begin
                  gap_cnt <= GAP_WB;
                  gap_next <= S_WAIT;
                  state <= S_GAP;
               end
               default: begin
                  len <= 12'h001;
                  gap_cnt <= GAP_WHR;
                  gap_next <= S_DOUT;
                  state <= S_GAP;
               end
               endcase
            end
         end
         S_ADDR: begin
            if (!ph) begin
               cle <= 1'b0;
               ale <= 1'b1;
               io_out <= {8'h00, addr_byte};
               we_n <= 1'b0;
               ph <= 1'b1;
            end else begin
               we_n <= 1'b1;
               ph <= 1'b0;
               if (cnt == addr_last) begin
                  cnt <= 12'h000;
                  case (op)
                  `OP_ID: begin
                     gap_cnt <= GAP_WHR;
                     gap_next <= S_DOUT;
                     state <= S_GAP;
                  end
                  `OP_PROG, `OP_CACHE: begin
                     gap_cnt <= GAP_ADL;
                     gap_next <= S_DIN;
                     state <= S_GAP;
                  end
                  default: begin
                     cmd_byte <= `CMD_READ_GO;
                     state <= S_CMD;
                  end
                  endcase
               end else begin
                  cnt <= cnt + 12'h001;
               end
            end
         end
         S_GAP: begin
            cle <= 1'b0;
            ale <= 1'b0;
            if (gap_cnt == 4'h0)
               state <= gap_next;
            else
               gap_cnt <= gap_cnt - 4'h1;
         end
         S_WAIT: begin
            // ready/busy is only trusted after its synchroniser settles
            if (rb_s) begin
               cnt <= 12'h000;
               ph <= 1'b0;
               if (op == `OP_PROG || op == `OP_CACHE) begin
                  cmd_byte <= `CMD_STATUS;
                  state <= S_CMD;
               end else begin
                  state <= S_DOUT;
               end
            end else if (busy_cnt == BUSY_LIMIT) begin
               err <= 1'b1;
               state <= S_DONE;
            end else begin
               busy_cnt <= busy_cnt + 15'h0001;
            end
         end
         S_DIN: begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b1;
            if (ph) begin
               we_n <= 1'b1;
               ph <= 1'b0;
               cnt <= cnt + 12'h001;
            end else if (cnt == len) begin
               ce_n <= 1'b0;
               cmd_byte <= (op == `OP_CACHE) ? `CMD_CACHE_GO :
                           `CMD_PROG_GO;
               state <= S_CMD;
            end else if (!wr_valid) begin
               ce_n <= 1'b1;
            end else if (ce_n) begin
               // one cycle of chip-enable setup before the strobe
               ce_n <= 1'b0;
            end else begin
               io_out <= X16 ? wr_data : {8'h00, wr_data[7:0]};
               we_n <= 1'b0;
               wr_take <= 1'b1;
               ph <= 1'b1;
            end
         end
         S_DOUT: begin
            cle <= 1'b0;
            ale <= 1'b0;
            we_n <= 1'b1;
            io_oe <= 1'b0;
            if (ph) begin
               output_strobe_n <= 1'b1;
               ph <= 1'b0;
               cnt <= cnt + 12'h001;
               // raw data; ecc correction belongs to the layer above
               rd_data <= X16 ? io_in : {8'h00, io_in[7:0]};
               rd_valid <= (op == `OP_READ) || (op == `OP_ID);
            end else if (cnt != len) begin
               output_strobe_n <= 1'b0;
               ph <= 1'b1;
            end else begin
               state <= S_DONE;
               case (op)
               `OP_SCAN: begin
                  if (marker_bad || pg[0]) begin
                     bbt_wen <= 1'b1;
                     bbt_wbad <= marker_bad;
                  end else begin
                     pg <= 6'h01;
                     cmd_byte <= `CMD_READ;
                     state <= S_CMD;
                  end
               end
               `OP_PROG, `OP_CACHE: begin
                  if (rd_data[`STAT_FAIL_BIT]) begin
                     bbt_wen <= 1'b1;
                     bbt_wbad <= 1'b1;
                     err <= 1'b1;
                     fail_row <= row;
                  end else begin
                     prog_valid <= 1'b1;
                     prog_blk <= blk;
                     prog_next <= {1'b0, pg} + 7'h01;
                     if (op != `OP_CACHE)
                        cache_cnt <= 6'h00;
                     else if (same_blk)
                        cache_cnt <= cache_cnt + 6'h01;
                     else
                        cache_cnt <= 6'h01;
                  end
               end
               default: begin
               end
               endcase
            end
         end
         S_DONE: begin
            ce_n <= 1'b1;
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            done <= 1'b1;
            cmd_ready <= 1'b1;
            state <= S_IDLE;
         end
         default: state <= S_IDLE;
         endcase
      end
   end
endmodule // nand_host

`default_nettype wire

// File: src/nand_host_defines.vh
/*
 constants for the nand host controller: command bytes, operations,
 page geometry and timing counts. assumes a 25 MHz controller clock.
*/
`ifndef NAND_HOST_DEFINES_VH
`define NAND_HOST_DEFINES_VH

`define CLK_NS 40
`define T_ADL_NS 100
`define T_WB_NS 100
`define T_WHR_NS 60
`define T_CBSY_US 700
// least times round up, longest times round down
`define T_ADL_CYC ((`T_ADL_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WB_CYC ((`T_WB_NS + `CLK_NS - 1) / `CLK_NS)
`define T_WHR_CYC ((`T_WHR_NS + `CLK_NS - 1) / `CLK_NS)
`define T_CBSY_CYC ((`T_CBSY_US * 1000) / `CLK_NS)
`define SYNC_STAGES 3

`define CMD_READ 8'h00
`define CMD_READ_GO 8'h30
`define CMD_DATA_IN 8'h80
`define CMD_PROG_GO 8'h10
`define CMD_CACHE_GO 8'h15
`define CMD_STATUS 8'h70
`define CMD_READ_ID 8'h90

`define OP_READ 3'h0
`define OP_PROG 3'h1
`define OP_CACHE 3'h2
`define OP_ID 3'h3
`define OP_SCAN 3'h4

`define ADDR_LAST 12'h004
`define PAGE_MAX_X8 12'h840
`define PAGE_MAX_X16 12'h420
`define SPARE_COL_X8 12'h800
`define SPARE_COL_X16 12'h400
`define CACHE_MAX 6'h3F
`define ID_BYTES 12'h004
`define STAT_FAIL_BIT 0

`endif

// File: src/nand_pin_sync.v
/*
 three-stage input synchroniser with agreement filter.
 assumes the input is asynchronous to clk; output changes only when
 the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module nand_pin_sync #(
   parameter W = 1,
   parameter [W-1:0] INIT = {W{1'b1}}
) (
   input wire clk,
   input wire rstn,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] s1;
   reg [W-1:0] s2;
   reg [W-1:0] s3;

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         q <= INIT;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         // a glitch seen in one stage only is ignored
         if (s2 == s3)
            q <= s3;
      end
   end
endmodule // nand_pin_sync

`default_nettype wire
